/* ecpwm_pkg.sv */
// Package for the eight channel pulse width modulation timer.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package ecpwm_pkg;

  localparam int unsigned ECPWM_CHANNELS = 8;
  localparam int unsigned ECPWM_PAIRS    = 4;

  // Register byte offsets.
  localparam logic [7:0] ECPWM_ENABLE_OFS   = 8'h00;
  localparam logic [7:0] ECPWM_POLARITY_OFS = 8'h04;
  localparam logic [7:0] ECPWM_CENTER_OFS   = 8'h08;
  localparam logic [7:0] ECPWM_CONCAT_OFS   = 8'h0c;
  localparam logic [7:0] ECPWM_PCM_OFS      = 8'h10;
  localparam logic [7:0] ECPWM_OUTPUT_OFS   = 8'h14;
  localparam logic [7:0] ECPWM_PERIOD_OFS   = 8'h20;
  localparam logic [7:0] ECPWM_DUTY_OFS     = 8'h40;
  localparam logic [7:0] ECPWM_COUNT_OFS    = 8'h60;

  // Reset values.
  localparam logic [7:0] ECPWM_CTRL_RST   = 8'h00;
  localparam logic [7:0] ECPWM_PERIOD_RST = 8'hff;
  localparam logic [7:0] ECPWM_DUTY_RST   = 8'h00;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] polarity;
    logic [7:0] center;
    logic [3:0] concat;
    logic [7:0] pcm;
  } ecpwm_ctrl_type;

  typedef struct packed {
    logic        en;
    logic        pol;
    logic        center;
    logic        pcm;
    logic        wide;
    logic [15:0] period;
    logic [15:0] duty;
  } ecpwm_chan_cfg_type;

  typedef struct packed {
    logic [15:0] count;
    logic        down;
    logic [15:0] accum;
    logic        out;
  } ecpwm_chan_state_type;

endpackage : ecpwm_pkg

/* ecpwm_channel.sv */
// One modulator channel, 8 bits wide or 16 bits wide when joined to its neighbour.
// Assumes configuration comes from registers on the same clock.
`timescale 1ns/100ps
module ecpwm_channel
  import ecpwm_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire ecpwm_chan_cfg_type cfg_i,
  output logic [15:0]             count_o,
  output logic                    out_o
);

  ecpwm_chan_state_type st_q;
  ecpwm_chan_state_type st_d;
  logic [15:0]          mask;
  logic [16:0]          sum;
  logic                 active;

  always_comb begin
    st_d   = st_q;
    mask   = cfg_i.wide ? 16'hffff : 16'h00ff;
    sum    = 17'(st_q.accum) + 17'(cfg_i.duty & mask);
    active = 1'b0;
    if (!cfg_i.en) begin
      st_d.count = 16'h0000;
      st_d.down  = 1'b0;
      st_d.accum = 16'h0000;
    end else if (cfg_i.center) begin
      // Up to the period and back down to zero doubles the period.
      if (!st_q.down) begin
        if (st_q.count >= (cfg_i.period & mask)) begin
          st_d.down  = 1'b1;
          st_d.count = st_q.count - 16'h0001;
        end else begin
          st_d.count = st_q.count + 16'h0001;
        end
      end else if (st_q.count == 16'h0000) begin
        st_d.down  = 1'b0;
        st_d.count = 16'h0001;
      end else begin
        st_d.count = st_q.count - 16'h0001;
      end
      if (st_d.count > (cfg_i.period & mask)) begin
        st_d.count = 16'h0000;
      end
      active = st_q.count < (cfg_i.duty & mask);
    end else begin
      st_d.count = (st_q.count >= (cfg_i.period & mask)) ? 16'h0000 : st_q.count + 16'h0001;
      active     = st_q.count < (cfg_i.duty & mask);
    end
    if (cfg_i.en && cfg_i.pcm) begin
      // Density modulation spreads active cycles evenly over the period.
      if (sum > 17'(cfg_i.period & mask)) begin
        st_d.accum = 16'(sum - 17'(cfg_i.period & mask) - 17'h0_0001);
        active     = 1'b1;
      end else begin
        st_d.accum = sum[15:0];
        active     = 1'b0;
      end
    end
    if (cfg_i.en && ((cfg_i.duty & mask) > (cfg_i.period & mask))) begin
      active = 1'b1;
    end
    st_d.out = (cfg_i.en & active) ^ cfg_i.pol;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_o = st_q.count;
  assign out_o   = st_q.out;

endmodule : ecpwm_channel

/* ecpwm_top.sv */
// Eight channel pulse width modulation timer with a Wishbone register file.
// Assumes a classic Wishbone master on clk_i; outputs drive device pins.
// Functional notes
// - Eight independent channels each have an 8-bit counter and their own period and duty registers.
// - Each channel runs continuously and its duty covers 0% (never active) to 100% (always active), but a full-scale period tops out one cycle short of 100%.
// - A per channel polarity bit chooses whether the active phase drives high or low.
// - A per channel bit chooses edge aligned or center aligned pulses.
// - Pairs 7/6, 5/4, 3/2 and 1/0 may be joined into one channel with 16-bit counter, period and duty.
// - Joining is chosen per pair, giving any mix from eight 8-bit to four 16-bit channels.
// - A per channel bit selects pulse code modulated output in place of conventional modulation.
`timescale 1ns/100ps
module ecpwm_top
  import ecpwm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [7:0]  pwm_o
);

  typedef struct packed {
    ecpwm_ctrl_type ctrl;
    logic [7:0][7:0] period;
    logic [7:0][7:0] duty;
    logic [31:0]    rdata;
    logic [7:0]     pins;
    logic           ack;
  } ecpwm_regs_type;

  ecpwm_regs_type        r_q;
  ecpwm_regs_type        r_d;
  ecpwm_chan_cfg_type [7:0] cfg;
  logic [7:0][15:0]      count;
  logic [7:0]            raw_out;
  logic                  req;
  logic [2:0]            idx;

  assign req = wb_cyc_i & wb_stb_i & ~r_q.ack;
  assign idx = wb_adr_i[4:2];

  always_comb begin
    r_d       = r_q;
    r_d.ack   = req;
    r_d.rdata = 32'h0000_0000;
    // The pins take one more flop after the channel so every output leaves a register.
    r_d.pins  = raw_out;
    if (req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i[7:5])
        3'h0: begin
          unique case (wb_adr_i[4:0])
            ECPWM_ENABLE_OFS[4:0]:   r_d.ctrl.enable   = wb_dat_i[7:0];
            ECPWM_POLARITY_OFS[4:0]: r_d.ctrl.polarity = wb_dat_i[7:0];
            ECPWM_CENTER_OFS[4:0]:   r_d.ctrl.center   = wb_dat_i[7:0];
            ECPWM_CONCAT_OFS[4:0]:   r_d.ctrl.concat   = wb_dat_i[3:0];
            ECPWM_PCM_OFS[4:0]:      r_d.ctrl.pcm      = wb_dat_i[7:0];
            default: ;
          endcase
        end
        3'h1:    r_d.period[idx] = wb_dat_i[7:0];
        3'h2:    r_d.duty[idx]   = wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i[7:5])
        3'h0: begin
          unique case (wb_adr_i[4:0])
            ECPWM_ENABLE_OFS[4:0]:   r_d.rdata = {24'h00_0000, r_q.ctrl.enable};
            ECPWM_POLARITY_OFS[4:0]: r_d.rdata = {24'h00_0000, r_q.ctrl.polarity};
            ECPWM_CENTER_OFS[4:0]:   r_d.rdata = {24'h00_0000, r_q.ctrl.center};
            ECPWM_CONCAT_OFS[4:0]:   r_d.rdata = {28'h000_0000, r_q.ctrl.concat};
            ECPWM_PCM_OFS[4:0]:      r_d.rdata = {24'h00_0000, r_q.ctrl.pcm};
            ECPWM_OUTPUT_OFS[4:0]:   r_d.rdata = {24'h00_0000, r_q.pins};
            default:                 r_d.rdata = 32'h0000_0000;
          endcase
        end
        3'h1:    r_d.rdata = {24'h00_0000, r_q.period[idx]};
        3'h2:    r_d.rdata = {24'h00_0000, r_q.duty[idx]};
        3'h3:    r_d.rdata = {16'h0000, count[idx]};
        default: r_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q.ctrl     <= '{ECPWM_CTRL_RST, ECPWM_CTRL_RST, ECPWM_CTRL_RST, ECPWM_CTRL_RST[3:0], ECPWM_CTRL_RST};
      r_q.period   <= {8{ECPWM_PERIOD_RST}};
      r_q.duty     <= {8{ECPWM_DUTY_RST}};
      r_q.rdata    <= 32'h0000_0000;
      r_q.pins     <= 8'h00;
      r_q.ack      <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // In a joined pair the odd channel holds the high byte and the even one drives the pin.
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      cfg[c].wide   = r_q.ctrl.concat[c/2];
      cfg[c].en     = r_q.ctrl.enable[c] & ~(cfg[c].wide & (c % 2 == 1));
      cfg[c].pol    = r_q.ctrl.polarity[c];
      cfg[c].center = r_q.ctrl.center[c];
      cfg[c].pcm    = r_q.ctrl.pcm[c];
      if (cfg[c].wide && (c % 2 == 0)) begin
        cfg[c].period = {r_q.period[c | 1], r_q.period[c]};
        cfg[c].duty   = {r_q.duty[c | 1], r_q.duty[c]};
      end else begin
        cfg[c].period = {8'h00, r_q.period[c]};
        cfg[c].duty   = {8'h00, r_q.duty[c]};
      end
    end
  end

  for (genvar g = 0; g < ECPWM_CHANNELS; g++) begin : g_chan
    ecpwm_channel u_chan (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .cfg_i   (cfg[g]),
      .count_o (count[g]),
      .out_o   (raw_out[g])
    );
  end

  assign wb_dat_o = r_q.rdata;
  assign wb_ack_o = r_q.ack;
  assign pwm_o    = r_q.pins;

endmodule : ecpwm_top

/* ecpwm_assertions.sv */
// Checker for the pwm timer bus handshake, register readback and pins.
// Assumes it is bound to ecpwm_top and sees only its ports.
`timescale 1ns/100ps
module ecpwm_checker
  import ecpwm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  pwm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] en_q;
  // The shadow copy lands at the ack edge, so it lags the register by a cycle at most.
  always_ff @(posedge clk_i) begin
    if (rst_i) en_q <= 8'h00;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ECPWM_ENABLE_OFS) en_q <= wb_dat_i[7:0];
  end
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_ack_held; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_held: assert property (p_ack_held) else $error("ack idle");
  // Counters of a joined pair are 16 bits wide, so only they may use the second byte.
  property p_hi_zero; wb_ack_o && !wb_we_i && wb_adr_i[7:5] != 3'h3 |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  property p_cnt_hi; wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("counter upper bits set");
  property p_out_rb; wb_ack_o && !wb_we_i && wb_adr_i == ECPWM_OUTPUT_OFS |-> wb_dat_o[7:0] == $past(pwm_o); endproperty
  a_out_rb: assert property (p_out_rb) else $error("pin readback");
  property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> wb_dat_o == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_enable_rb; wb_ack_o && !wb_we_i && wb_adr_i == ECPWM_ENABLE_OFS |-> wb_dat_o[7:0] == en_q; endproperty
  a_enable_rb: assert property (p_enable_rb) else $error("enable readback");
  property p_pins_rst; $fell(rst_i) |-> pwm_o == 8'h00 ##1 pwm_o == 8'h00; endproperty
  a_pins_rst: assert property (p_pins_rst) else $error("pins after reset");
endmodule : ecpwm_checker
bind ecpwm_top ecpwm_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pwm_o(pwm_o));

/* test_ecpwm_top.sv */
// Self-checking bench for the pwm timer: registers over Wishbone, duty counts on the pins.
// Assumes a 4 ns clock and the register map of the package.
`timescale 1ns/100ps
module test_ecpwm_top;
  import ecpwm_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00, pwm_o, prev;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic [3:0]  wb_sel_i = 4'h0;
  int          n_mismatch = 0, check_count = 0, cyc_n = 0, rs, hi [8];
  ecpwm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pwm_o(pwm_o));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic cycle; the master waits for ack and then idles one cycle before the next.
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rchk(logic [7:0] a, logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    check("register", r, exp);
  endtask : rchk
  task automatic cfg(logic [7:0] ch, logic [7:0] p, logic [7:0] d);
    wr(ECPWM_PERIOD_OFS + (ch << 2), p);
    wr(ECPWM_DUTY_OFS + (ch << 2), d);
  endtask : cfg
  // Settles first, so the two cycle pin delay never splits a period in the window.
  task automatic meas(int n);
    repeat (16) @(posedge clk_i);
    hi = '{default: 0};
    rs = 0;
    prev = pwm_o;
    repeat (n) begin
      @(posedge clk_i);
      for (int i = 0; i < 8; i++) hi[i] += pwm_o[i];
      rs += (pwm_o[0] && !prev[0]);
      prev = pwm_o;
    end
  endtask : meas
  task automatic t_reset;
    rchk(ECPWM_ENABLE_OFS, 32'h0000_0000);
    rchk(ECPWM_PERIOD_OFS + 8'h1c, 32'h0000_00ff);
    rchk(ECPWM_DUTY_OFS, 32'h0000_0000);
    rchk(ECPWM_OUTPUT_OFS, 32'h0000_0000);
    rchk(ECPWM_COUNT_OFS, 32'h0000_0000);
    wr(8'h18, 8'h5a);
    rchk(8'h18, 32'h0000_0000);
  endtask : t_reset
  task automatic t_mix;
    cfg(8'h00, 8'h03, 8'h00);
    cfg(8'h01, 8'h03, 8'h04);
    cfg(8'h02, 8'h03, 8'h01);
    cfg(8'h03, 8'h03, 8'h01);
    wr(ECPWM_CENTER_OFS, 8'h08);
    wr(ECPWM_POLARITY_OFS, 8'h01);
    wr(ECPWM_ENABLE_OFS, 8'h0f);
    rchk(ECPWM_ENABLE_OFS, 32'h0000_000f);
    meas(48);
    check("zero duty inverted", hi[0], 48);
    check("full duty", hi[1], 48);
    check("edge duty", hi[2], 12);
    check("center duty", hi[3], 8);
    check("disabled", hi[4], 0);
  endtask : t_mix
  task automatic t_join;
    wr(ECPWM_POLARITY_OFS, 8'h00);
    wr(ECPWM_CENTER_OFS, 8'h00);
    cfg(8'h00, 8'h00, 8'h80);
    cfg(8'h01, 8'h01, 8'h00);
    cfg(8'h02, 8'h01, 8'h01);
    wr(ECPWM_CONCAT_OFS, 8'h01);
    wr(ECPWM_ENABLE_OFS, 8'h05);
    meas(514);
    check("joined duty", hi[0], 256);
    check("odd pin idle", hi[1], 0);
    check("unjoined pair", hi[2], 257);
  endtask : t_join
  task automatic t_pcm;
    wr(ECPWM_CONCAT_OFS, 8'h00);
    cfg(8'h00, 8'h07, 8'h04);
    wr(ECPWM_PCM_OFS, 8'h01);
    wr(ECPWM_ENABLE_OFS, 8'h01);
    meas(80);
    check("pcm density", hi[0], 40);
    check("pcm spread", rs >= 20, 1);
  endtask : t_pcm
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_mix();
    t_join();
    t_pcm();
    give_verdict();
  end
endmodule : test_ecpwm_top
